// File: design/sqc_cmd_ram.sv
`timescale 1ns/100ps
module sqc_cmd_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data_ff;

    // contents are undefined until software loads them
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_data_ff <= '0;
        end
        else
        begin
            rd_data_ff <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;
endmodule

// File: design/sqc_pkg.sv
package sqc_pkg;

    // avalon slave geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int REG_W = 16;
    localparam int BE_HI = 1;
    localparam int BE_LO = 0;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_WRAP = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_START = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_RAM_ADDR = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_RAM_DATA = 5'h10;

    // queue geometry
    localparam int PTR_W = 4;
    localparam int ENTRIES = 16;
    localparam int CS_W = 4;
    localparam int CMD_W = 8;
    localparam int WORD_BITS = 8;
    localparam int BITCNT_W = 4;

    // field positions
    localparam int TE_BIT = 15;
    localparam int RAM_DATA_LSB = 8;
    localparam int RAM_ADDR_LSB = 0;

    // reset values and write masks
    localparam logic [REG_W-1:0] WRAP_RST = 16'h0000;
    localparam logic [REG_W-1:0] IRQ_RST = 16'h0000;
    localparam logic [REG_W-1:0] IRQ_EN_MASK = 16'hdd00;
    localparam logic [REG_W-1:0] IRQ_FLAG_MASK = 16'h000d;
    localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
    localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
    localparam logic [BITCNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [BITCNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CMD_W-1:0] CMD_RST = 8'h00;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic halt;
        logic wrap_enable;
        logic wrap_target_select;
        logic cs_idle_level;
        logic [PTR_W-1:0] end_queue_ptr;
        logic [PTR_W-1:0] completed_ptr;
        logic [PTR_W-1:0] start_queue_ptr;
    } sqc_wrap_t;

    typedef struct packed {
        logic collision_error_en;
        logic abort_error_en;
        logic rsvd13;
        logic abort_lockout;
        logic collision_irq_en;
        logic abort_irq_en;
        logic rsvd9;
        logic finished_irq_en;
        logic [3:0] rsvd7_4;
        logic collision_flag;
        logic abort_flag;
        logic rsvd1;
        logic finished_flag;
    } sqc_irq_t;

    typedef struct packed {
        logic continuous_select;
        logic [2:0] options;
        logic [CS_W-1:0] chip_sel;
    } sqc_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_SHIFT = 2'b10,
        ST_NEXT = 2'b11
    } sqc_state_t;

endpackage

// File: design/sqc_queue_ctrl.sv
`timescale 1ns/100ps
module sqc_queue_ctrl
    import sqc_pkg::*;
#(
    parameter int WORD_LEN = sqc_pkg::WORD_BITS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [sqc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [sqc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [sqc_pkg::BE_W-1:0] avs_byteenable,
    output logic [sqc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic sclk_in,
    output logic [sqc_pkg::CS_W-1:0] cs_out,
    output logic word_done,
    output logic irq
);
    import sqc_pkg::*;

    localparam logic [BITCNT_W-1:0] LAST_BIT = BITCNT_W'(WORD_LEN - 1);

    function automatic logic [REG_W-1:0] be_merge(
        input logic [REG_W-1:0] old,
        input logic [DATA_W-1:0] wd,
        input logic [BE_W-1:0] be
    );
        logic [REG_W-1:0] res;
        res = old;
        if (be[BE_HI])
        begin
            res[REG_W-1:RAM_DATA_LSB] = wd[REG_W-1:RAM_DATA_LSB];
        end
        if (be[BE_LO])
        begin
            res[RAM_DATA_LSB-1:0] = wd[RAM_DATA_LSB-1:0];
        end
        return res;
    endfunction

    function automatic logic [CS_W-1:0] idle_word(input logic level);
        return {CS_W{level}};
    endfunction

    // register state
    sqc_wrap_t wrap_ff;
    sqc_irq_t irq_reg_ff;
    logic te_ff;
    logic [PTR_W-1:0] ram_addr_ff;
    logic [PTR_W-1:0] cpl_ff;

    // bus handshake state
    logic ack_ff;
    logic [DATA_W-1:0] readdata_ff;
    logic [1:0] resp_ff;
    logic coll_ff;
    logic wblock_ff;
    logic te_clr_ok_ff;
    logic abort_set_ff;

    // engine state
    sqc_state_t state_ff;
    sqc_state_t nxt_state;
    logic [PTR_W-1:0] cur_ptr_ff;
    logic [PTR_W-1:0] nxt_ptr;
    logic [BITCNT_W-1:0] cnt_ff;
    logic [BITCNT_W-1:0] nxt_cnt;
    logic [PTR_W-1:0] nxt_cpl;
    logic [CS_W-1:0] cs_ff;
    logic [CS_W-1:0] nxt_cs;
    logic word_done_ff;
    logic nxt_word_done;
    logic fin_set;
    logic dev_clr;
    logic irq_ff;

    // serial clock synchroniser
    logic sclk_s1_ff;
    logic sclk_s2_ff;
    logic sclk_s3_ff;

    logic [CMD_W-1:0] ram_rd_data;
    sqc_cmd_t cmd;

    // address decode and handshake
    wire req = avs_read | avs_write;
    wire first = req & ~ack_ff;
    wire wr_go = avs_write & ack_ff;
    wire sel_wrap = avs_address == OFS_WRAP;
    wire sel_irq = avs_address == OFS_IRQ;
    wire sel_start = avs_address == OFS_START;
    wire sel_radr = avs_address == OFS_RAM_ADDR;
    wire sel_rdat = avs_address == OFS_RAM_DATA;
    wire busy = state_ff != ST_IDLE;
    wire sclk_rise = sclk_s2_ff & ~sclk_s3_ff;

    // one wait state: decisions are taken in the first cycle and committed at the accept edge,
    // so a write never sees a different engine state than the answer it got
    wire coll_hit = avs_write & sel_rdat & busy & (ram_addr_ff == cur_ptr_ff);
    wire coll_err = coll_hit & irq_reg_ff.collision_error_en;
    wire te_clr_try = avs_write & sel_start & avs_byteenable[BE_HI] & ~avs_writedata[TE_BIT] & busy;
    wire abort_err = te_clr_try & irq_reg_ff.abort_error_en;
    wire te_clr_ok = ~te_clr_try | (~irq_reg_ff.abort_lockout & ~irq_reg_ff.abort_error_en);
    wire access_err = coll_err | abort_err;

    wire [REG_W-1:0] wrap_rd = {wrap_ff.halt, wrap_ff.wrap_enable, wrap_ff.wrap_target_select,
        wrap_ff.cs_idle_level, wrap_ff.end_queue_ptr, cpl_ff, wrap_ff.start_queue_ptr};
    wire [REG_W-1:0] irq_rd = irq_reg_ff & (IRQ_EN_MASK | IRQ_FLAG_MASK);
    wire [REG_W-1:0] start_rd = REG_W'({te_ff}) << TE_BIT;
    wire [REG_W-1:0] radr_rd = REG_W'(ram_addr_ff) << RAM_ADDR_LSB;
    wire [REG_W-1:0] rd_mux = sel_wrap ? wrap_rd :
                              sel_irq ? irq_rd :
                              sel_start ? start_rd :
                              sel_radr ? radr_rd : '0;

    // register write side
    wire [REG_W-1:0] wrap_wr = be_merge(wrap_ff, avs_writedata, avs_byteenable);
    wire [REG_W-1:0] irq_en_wr = be_merge(irq_reg_ff, avs_writedata, avs_byteenable) & IRQ_EN_MASK;
    wire [REG_W-1:0] w1c = be_merge('0, avs_writedata, avs_byteenable) & IRQ_FLAG_MASK;
    wire [REG_W-1:0] flag_clr = (wr_go & sel_irq) ? w1c : '0;
    wire [REG_W-1:0] flag_set = {12'h000, wr_go & coll_ff, wr_go & abort_set_ff, 1'b0, fin_set};
    wire [REG_W-1:0] flags_nxt = ((irq_reg_ff & IRQ_FLAG_MASK & ~flag_clr) | flag_set);
    wire ram_wr = wr_go & sel_rdat & avs_byteenable[BE_HI] & ~wblock_ff;
    wire te_wr = wr_go & sel_start & avs_byteenable[BE_HI];
    wire irq_nxt = (irq_reg_ff.collision_flag & irq_reg_ff.collision_irq_en) |
                   (irq_reg_ff.abort_flag & irq_reg_ff.abort_irq_en) |
                   (irq_reg_ff.finished_flag & irq_reg_ff.finished_irq_en);

    // queue decisions
    wire last_entry = cur_ptr_ff == wrap_ff.end_queue_ptr;
    wire [PTR_W-1:0] wrap_ptr = wrap_ff.wrap_target_select ? wrap_ff.start_queue_ptr : PTR_ZERO;
    wire stop_now = wrap_ff.halt | (last_entry & ~wrap_ff.wrap_enable);
    wire [CS_W-1:0] cs_idle = idle_word(wrap_ff.cs_idle_level);

    assign cmd = sqc_cmd_t'(ram_rd_data);

    sqc_cmd_ram #(
        .WIDTH(CMD_W),
        .DEPTH(ENTRIES),
        .AW(PTR_W)
    ) u_cmd_ram (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(ram_wr),
        .wr_addr(ram_addr_ff),
        .wr_data(avs_writedata[RAM_DATA_LSB+CMD_W-1:RAM_DATA_LSB]),
        .rd_addr(cur_ptr_ff),
        .rd_data(ram_rd_data)
    );

    always_comb
    begin
        nxt_state = state_ff;
        nxt_ptr = cur_ptr_ff;
        nxt_cnt = cnt_ff;
        nxt_cpl = cpl_ff;
        nxt_cs = cs_ff;
        nxt_word_done = 1'b0;
        fin_set = 1'b0;
        dev_clr = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_cs = cs_idle;
                if (te_ff)
                begin
                    nxt_ptr = wrap_ff.start_queue_ptr;
                    nxt_state = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                nxt_cnt = CNT_ZERO;
                nxt_state = ST_SHIFT;
            end
            ST_SHIFT:
            begin
                nxt_cs = cmd.chip_sel;
                if (sclk_rise)
                begin
                    if (cnt_ff == LAST_BIT)
                    begin
                        nxt_word_done = 1'b1;
                        nxt_state = ST_NEXT;
                    end
                    else
                    begin
                        nxt_cnt = cnt_ff + CNT_ONE;
                    end
                end
            end
            ST_NEXT:
            begin
                nxt_cpl = cur_ptr_ff;
                if (!cmd.continuous_select)
                begin
                    nxt_cs = cs_idle;
                end
                if (stop_now)
                begin
                    fin_set = 1'b1;
                    dev_clr = 1'b1;
                    nxt_cs = cs_idle;
                    nxt_state = ST_IDLE;
                end
                else if (last_entry)
                begin
                    fin_set = 1'b1;
                    nxt_ptr = wrap_ptr;
                    nxt_state = ST_FETCH;
                end
                else
                begin
                    nxt_ptr = cur_ptr_ff + PTR_ONE;
                    nxt_state = ST_FETCH;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        // software cleared transfer enable: drop the queue at once
        if (!te_ff && busy)
        begin
            nxt_state = ST_IDLE;
            nxt_cs = cs_idle;
            fin_set = 1'b0;
            dev_clr = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_s3_ff <= 1'b0;
        end
        else
        begin
            sclk_s1_ff <= sclk_in;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_ff <= 1'b0;
            readdata_ff <= '0;
            resp_ff <= RESP_OKAY;
            coll_ff <= 1'b0;
            wblock_ff <= 1'b0;
            te_clr_ok_ff <= 1'b0;
            abort_set_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= first;
            if (first)
            begin
                readdata_ff <= avs_read ? DATA_W'(rd_mux) : '0;
                resp_ff <= access_err ? RESP_SLVERR : RESP_OKAY;
                coll_ff <= coll_hit;
                wblock_ff <= coll_err;
                te_clr_ok_ff <= te_clr_ok;
                abort_set_ff <= te_clr_try & te_clr_ok;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrap_ff <= sqc_wrap_t'(WRAP_RST);
            irq_reg_ff <= sqc_irq_t'(IRQ_RST);
            te_ff <= 1'b0;
            ram_addr_ff <= PTR_RST;
            irq_ff <= 1'b0;
        end
        else
        begin
            if (wr_go && sel_wrap)
            begin
                wrap_ff <= sqc_wrap_t'(wrap_wr);
            end
            irq_reg_ff <= sqc_irq_t'(((wr_go && sel_irq) ? irq_en_wr : (irq_reg_ff & IRQ_EN_MASK)) | flags_nxt);
            if (te_wr && avs_writedata[TE_BIT])
            begin
                te_ff <= 1'b1;
            end
            else if (te_wr && te_clr_ok_ff)
            begin
                te_ff <= 1'b0;
            end
            else if (dev_clr)
            begin
                te_ff <= 1'b0;
            end
            if (wr_go && sel_radr && avs_byteenable[BE_LO])
            begin
                ram_addr_ff <= avs_writedata[RAM_ADDR_LSB+PTR_W-1:RAM_ADDR_LSB];
            end
            else if (ram_wr)
            begin
                ram_addr_ff <= ram_addr_ff + PTR_ONE;
            end
            irq_ff <= irq_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            cur_ptr_ff <= PTR_RST;
            cnt_ff <= CNT_ZERO;
            cpl_ff <= PTR_RST;
            cs_ff <= idle_word(WRAP_RST[REG_W-4]);
            word_done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cur_ptr_ff <= nxt_ptr;
            cnt_ff <= nxt_cnt;
            cpl_ff <= nxt_cpl;
            cs_ff <= nxt_cs;
            word_done_ff <= nxt_word_done;
        end
    end

    assign avs_waitrequest = first;
    assign avs_readdata = readdata_ff;
    assign avs_response = resp_ff;
    assign cs_out = cs_ff;
    assign word_done = word_done_ff;
    assign irq = irq_ff;
endmodule

// File: testbench/sqc_periph_model.sv
`timescale 1ns/100ps
module sqc_periph_model (
    input wire logic [sqc_pkg::CS_W-1:0] cs_out,
    input wire logic idle_lvl,
    output logic sclk
);
    import sqc_pkg::*;
    logic sel;
    assign sel = cs_out != {CS_W{idle_lvl}};
    // clock only runs while selected, and rests low between frames;
    // the short settle ignores a select that flickers while the idle level moves,
    // and keeps the edges off the system clock's rising edge
    initial
    begin
        sclk = 1'b0;
        forever
        begin
            wait (sel);
            #5;
            while (sel)
            begin
                #80 sclk = 1'b1;
                #80 sclk = 1'b0;
            end
        end
    end
endmodule

// File: testbench/sqc_queue_ctrl_monitor.sv
`timescale 1ns/100ps
module sqc_queue_ctrl_monitor #(
    parameter int WORD_LEN = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [sqc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [sqc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [sqc_pkg::BE_W-1:0] avs_byteenable,
    input wire logic [sqc_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic sclk_in,
    input wire logic [sqc_pkg::CS_W-1:0] cs_out,
    input wire logic word_done,
    input wire logic irq
);
    import sqc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rd_acc;
    logic wr_acc;
    logic [DATA_W-1:0] q;
    assign rd_acc = avs_read && !avs_waitrequest;
    assign wr_acc = avs_write && !avs_waitrequest;
    assign q = avs_readdata;

    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
    a_wait_new_req: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("new request accepted without a wait state");
    a_wait_idle_low: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    a_read_resp_okay: assert property (rd_acc |-> avs_response == RESP_OKAY)
        else $error("read answered with an error");
    a_plain_write_okay: assert property (wr_acc && avs_address != OFS_RAM_DATA && avs_address != OFS_START
        |-> avs_response == RESP_OKAY)
        else $error("error response on a register that cannot fault");
    a_irq_rsvd_zero: assert property (rd_acc && avs_address == OFS_IRQ
        |-> q[31:16] == 16'h0 && q[13] == 1'b0 && q[9] == 1'b0 && q[7:4] == 4'h0 && q[1] == 1'b0)
        else $error("reserved interrupt bits read nonzero");
    a_irq_flag_match: assert property (rd_acc && avs_address == OFS_IRQ
        |-> irq == ((q[11] && q[3]) || (q[10] && q[2]) || (q[8] && q[0])))
        else $error("irq disagrees with enabled flags");
    a_port_read_zero: assert property (rd_acc && avs_address >= OFS_RAM_DATA |-> q == 32'h0)
        else $error("data port or unmapped read nonzero");
    a_done_pulse: assert property (word_done |=> !word_done)
        else $error("word_done longer than one cycle");
endmodule
bind sqc_queue_ctrl sqc_queue_ctrl_monitor #(.WORD_LEN(WORD_LEN)) u_mon (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .sclk_in(sclk_in), .cs_out(cs_out), .word_done(word_done), .irq(irq));

// File: testbench/sqc_queue_ctrl_tb.sv
`timescale 1ns/100ps
module sqc_queue_ctrl_tb;
    import sqc_pkg::*;
    logic clk, rst_n, rd, wr, sclk, wreq, wdone, irq, idle;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] wdat, rdat, got;
    logic [BE_W-1:0] be;
    logic [1:0] resp, gresp;
    logic [CS_W-1:0] cs;
    int error_cnt = 0;
    int num_checks = 0;
    sqc_queue_ctrl uut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .avs_response(resp), .sclk_in(sclk), .cs_out(cs), .word_done(wdone), .irq(irq));
    sqc_periph_model peer (.cs_out(cs), .idle_lvl(idle), .sclk(sclk));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(logic w, logic [ADDR_W-1:0] a, logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= {16'h0, d};
        be <= 4'h3;
        // waitrequest is judged at the rising edge, where the answer is also taken
        do
        begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            error_cnt++;
            finish_test();
        end
        got = rdat;
        gresp = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // waits for the next word end; keep marks an entry that holds its chip selects
    task automatic word(logic [CS_W-1:0] exp, logic keep = 1'b0);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (wdone !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            error_cnt++;
            finish_test();
        end
        check("cs_word", 32'(cs), 32'(exp));
        @(negedge clk);
        check("cs_after", 32'(cs), keep ? 32'(exp) : 32'({CS_W{idle}}));
    endtask

    task automatic t_reset();
        bus(0, OFS_WRAP, 16'h0);
        check("wrap_rst", got, 32'(WRAP_RST));
        bus(0, OFS_IRQ, 16'h0);
        check("irq_rst", got, 32'(IRQ_RST));
        bus(1, 5'h14, 16'hffff);
        bus(0, 5'h14, 16'h0);
        check("unmapped", got, 32'h0);
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (i == 0)
                bus(1, OFS_RAM_ADDR, 16'h0);
            bus(1, OFS_RAM_DATA, {4'h0, 4'h1 << (i % 4), 8'h00});
        end
        $display("reset and fill done");
    endtask

    task automatic t_basic();
        bus(1, OFS_IRQ, 16'h0100);
        bus(1, OFS_WRAP, 16'h02f1);
        bus(0, OFS_WRAP, 16'h0);
        check("cptr_ro", got, 32'h0201);
        bus(1, OFS_START, 16'h8000);
        word(4'h2);
        word(4'h4);
        bus(0, OFS_WRAP, 16'h0);
        check("cptr", got, 32'h0221);
        bus(0, OFS_START, 16'h0);
        check("te_self_clr", got, 32'h0);
        bus(1, OFS_IRQ, 16'h0100);
        bus(0, OFS_IRQ, 16'h0);
        check("fin_sticky", got, 32'h0101);
        check("irq_on", 32'(irq), 32'h1);
        bus(1, OFS_IRQ, 16'h0001);
        bus(0, OFS_IRQ, 16'h0);
        check("fin_w1c", got, 32'h0);
        check("irq_off", 32'(irq), 32'h0);
        $display("basic queue done");
    endtask

    task automatic t_wrap(logic tgt, logic lvl);
        bus(1, OFS_WRAP, {2'b01, tgt, lvl, 4'h3, 4'h0, 4'h2});
        // the model's idle level follows at the edge where the chip selects move
        @(posedge clk);
        idle <= lvl;
        bus(1, OFS_IRQ, 16'h0100);
        bus(1, OFS_START, 16'h8000);
        word(4'h4);
        word(4'h8);
        bus(0, OFS_IRQ, 16'h0);
        check("fin_wrap", got, 32'h0101);
        bus(1, OFS_IRQ, 16'h0101);
        word(tgt ? 4'h4 : 4'h1);
        bus(1, OFS_WRAP, {2'b11, tgt, lvl, 4'h3, 4'h0, 4'h2});
        word(tgt ? 4'h8 : 4'h2);
        bus(0, OFS_START, 16'h0);
        check("te_halt", got, 32'h0);
        bus(0, OFS_IRQ, 16'h0);
        check("fin_halt", got, 32'h0101);
        check("cs_halt", 32'(cs), 32'({CS_W{lvl}}));
        bus(1, OFS_IRQ, 16'h0000);
        bus(0, OFS_IRQ, 16'h0);
        check("fin_masked", got, 32'h0001);
        check("irq_masked", 32'(irq), 32'h0);
        bus(1, OFS_IRQ, 16'h0001);
        $display("wrap target %0d done", tgt);
    endtask

    task automatic t_err();
        bus(1, OFS_WRAP, 16'h0300);
        @(posedge clk);
        idle <= 1'b0;
        bus(1, OFS_IRQ, 16'hc800);
        bus(1, OFS_START, 16'h8000);
        bus(1, OFS_RAM_ADDR, 16'h0);
        bus(1, OFS_RAM_DATA, 16'h0100);
        check("coll_resp", 32'(gresp), 32'(RESP_SLVERR));
        bus(0, OFS_IRQ, 16'h0);
        check("coll_flag", got, 32'hc808);
        check("coll_irq", 32'(irq), 32'h1);
        bus(1, OFS_START, 16'h0);
        check("abort_flag_resp", 32'(gresp), 32'(RESP_SLVERR));
        bus(0, OFS_START, 16'h0);
        check("te_kept", got, 32'h8000);
        bus(1, OFS_IRQ, 16'h1008);
        bus(1, OFS_START, 16'h0);
        check("lock_resp", 32'(gresp), 32'(RESP_OKAY));
        bus(0, OFS_START, 16'h0);
        check("te_locked", got, 32'h8000);
        bus(0, OFS_IRQ, 16'h0);
        check("no_abort_flag", got, 32'h1000);
        bus(1, OFS_IRQ, 16'h0400);
        bus(1, OFS_START, 16'h0);
        bus(0, OFS_START, 16'h0);
        check("te_clr", got, 32'h0);
        bus(0, OFS_IRQ, 16'h0);
        check("abort_flag_flag", got, 32'h0404);
        check("abort_flag_irq", 32'(irq), 32'h1);
        check("cs_abort", 32'(cs), 32'h0);
        $display("errors and abort done");
    endtask

    task automatic t_continuous_select();
        bus(1, OFS_RAM_ADDR, 16'h0004);
        bus(1, OFS_RAM_DATA, 16'h8100);
        bus(1, OFS_WRAP, 16'h0504);
        bus(1, OFS_START, 16'h8000);
        word(4'h1, 1'b1);
        word(4'h2);
        bus(0, OFS_START, 16'h0);
        check("te_continuous_select", got, 32'h0);
        bus(0, OFS_WRAP, 16'h0);
        check("cptr_continuous_select", got, 32'h0554);
        $display("continuous select done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = '0;
        wdat = '0;
        be = '0;
        idle = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_basic();
        t_wrap(1'b0, 1'b0);
        t_wrap(1'b1, 1'b1);
        t_err();
        t_continuous_select();
        finish_test();
    end
endmodule
